// [core/mtrc_checker.v]
`timescale 1ns/10ps
`include "mtrc_consts.vh"
// Behaviour
// RL1: two independent ranges, each with own type
// RL2: uncached: no read or write allocation
// RL3: combining: no read allocation, writes may merge
// RL4: both ranges in one 64-bit register
// RL5: reset clears whole control register to zero
// RL6: low half range zero, high half one
// RL7: base holds upper 15 bits, 128K aligned
// RL8: hit when mask&base equals mask&address
// RL9: uncached over combine; both clear no effect
// RL10: range zero uncached bit0, combine bit1
// RL11: range one uncached bit32, combine bit33
// RL12: software keeps ranges at least 128K
// RL13: software aligns base to range size
// RL14: software keeps mask runs contiguous
// RL15: mask sets size, zero mask whole space
// RL16: merge buffer holds eight bytes
// RL17: both hit: uncached, then combining, then none
module mtrc_checker #(
  parameter ADDR_W = 32,
  parameter FIELD_W = 15
) (
  // clock, reset, enable
  input wire core_clk_in,
  input wire rst_n_in,
  input wire clk_en_in,
  // model-specific register access
  input wire msr_wr_in,
  input wire msr_rd_in,
  input wire [31:0] msr_addr_in,
  input wire [63:0] msr_wdata_in,
  output reg [63:0] msr_rdata_out,
  output reg msr_ack_out,
  output reg msr_err_out,
  // access classification request
  input wire acc_valid_in,
  input wire acc_write_in,
  input wire [ADDR_W-1:0] acc_addr_in,
  input wire [7:0] acc_be_in,
  input wire [63:0] acc_wdata_in,
  output reg cls_valid_out,
  output reg [1:0] cls_type_out,
  output reg cls_no_alloc_out,
  output reg cls_hit0_out,
  output reg cls_hit1_out,
  // merged bus write
  input wire flush_in,
  input wire bus_ready_in,
  output reg bus_wr_valid_out,
  output reg [ADDR_W-1:0] bus_wr_addr_out,
  output reg [63:0] bus_wr_data_out,
  output reg [7:0] bus_wr_be_out,
  // live register contents
  output reg [63:0] range_type_control_out
);
  reg [63:0] range_type_control_r; // both range descriptors [RL4]
  reg merge_valid_r; // merge buffer holds data
  reg [ADDR_W-4:0] merge_line_r; // 8-byte line address of the buffer
  reg [63:0] merge_data_r; // merged bytes [RL16]
  reg [7:0] merge_be_r; // bytes present
  reg [1:0] cls_type_nxt;
  wire hit0_w;
  wire hit1_w;
  wire [1:0] type0_w;
  wire [1:0] type1_w;
  wire addr_hit_w; // register address decode
  wire comb_wr_w; // write eligible for merging
  wire same_line_w;
  wire drain_w; // buffer must go to the bus
  integer i;

  // pick the more restrictive of two type codes [RL17]
  function [1:0] strictest;
    input [1:0] a;
    input [1:0] b;
    begin
      strictest = (a > b) ? a : b;
    end
  endfunction

  // per-range compare on its own half [RL1] [RL6]
  mtrc_range_match #(.FIELD_W(FIELD_W)) u_range0 (
    .desc_in(range_type_control_r[`MTRC_HALF0_LSB+31:`MTRC_HALF0_LSB]), // [RL10]
    .addr_hi_in(acc_addr_in[ADDR_W-1:ADDR_W-FIELD_W]),
    .hit_out(hit0_w),
    .type_out(type0_w)
  );
  mtrc_range_match #(.FIELD_W(FIELD_W)) u_range1 (
    .desc_in(range_type_control_r[`MTRC_HALF1_LSB+31:`MTRC_HALF1_LSB]), // [RL11]
    .addr_hi_in(acc_addr_in[ADDR_W-1:ADDR_W-FIELD_W]),
    .hit_out(hit1_w),
    .type_out(type1_w)
  );

  assign addr_hit_w = (msr_addr_in == `MTRC_MSR_ADDR);

  // combined type of the current access
  always @* begin
    cls_type_nxt = `MTRC_TYPE_NONE;
    if (hit0_w) begin
      cls_type_nxt = strictest(cls_type_nxt, type0_w);
    end
    if (hit1_w) begin
      cls_type_nxt = strictest(cls_type_nxt, type1_w); // [RL17]
    end
  end

  // only writes into combining ranges enter the buffer [RL3]
  assign comb_wr_w = acc_valid_in && acc_write_in && (cls_type_nxt == `MTRC_TYPE_WC);
  assign same_line_w = merge_line_r == acc_addr_in[ADDR_W-1:3];
  // drain on flush, on a non-mergeable access, when a new line starts, or when all eight bytes are present
  assign drain_w = merge_valid_r && (flush_in || (acc_valid_in && !comb_wr_w) ||
                   (comb_wr_w && !same_line_w) || (merge_be_r == 8'hFF));

  // register file
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      range_type_control_r <= `MTRC_RESET_VAL; // [RL5]
      msr_rdata_out <= 64'h0000000000000000;
      msr_ack_out <= 1'b0;
      msr_err_out <= 1'b0;
      range_type_control_out <= `MTRC_RESET_VAL;
    end else if (clk_en_in) begin
      msr_ack_out <= (msr_wr_in || msr_rd_in) && addr_hit_w;
      msr_err_out <= (msr_wr_in || msr_rd_in) && !addr_hit_w; // unmapped address
      if (msr_wr_in && addr_hit_w) begin
        range_type_control_r <= msr_wdata_in; // [RL4]
        range_type_control_out <= msr_wdata_in;
      end
      if (msr_rd_in && addr_hit_w) begin
        msr_rdata_out <= range_type_control_r;
      end else begin
        msr_rdata_out <= 64'h0000000000000000;
      end
    end
  end

  // classification result, registered one cycle after the request
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cls_valid_out <= 1'b0;
      cls_type_out <= `MTRC_TYPE_NONE;
      cls_no_alloc_out <= 1'b0;
      cls_hit0_out <= 1'b0;
      cls_hit1_out <= 1'b0;
    end else if (clk_en_in) begin
      cls_valid_out <= acc_valid_in;
      cls_type_out <= cls_type_nxt;
      // uncached and combining both forbid line allocation [RL2] [RL3]
      cls_no_alloc_out <= acc_valid_in && (cls_type_nxt != `MTRC_TYPE_NONE);
      cls_hit0_out <= acc_valid_in && hit0_w;
      cls_hit1_out <= acc_valid_in && hit1_w;
    end
  end

  // merge buffer and its single bus write [RL3] [RL16]
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      merge_valid_r <= 1'b0;
      merge_line_r <= {(ADDR_W-3){1'b0}};
      merge_data_r <= 64'h0000000000000000;
      merge_be_r <= 8'h00;
      bus_wr_valid_out <= 1'b0;
      bus_wr_addr_out <= {ADDR_W{1'b0}};
      bus_wr_data_out <= 64'h0000000000000000;
      bus_wr_be_out <= 8'h00;
    end else if (clk_en_in) begin
      if (bus_wr_valid_out && bus_ready_in) begin
        bus_wr_valid_out <= 1'b0; // write taken
      end
      if (drain_w && !bus_wr_valid_out) begin
        // hand the buffer to the bus as one write
        bus_wr_valid_out <= 1'b1;
        bus_wr_addr_out <= {merge_line_r, 3'h0};
        bus_wr_data_out <= merge_data_r;
        bus_wr_be_out <= merge_be_r;
        merge_valid_r <= 1'b0;
        merge_be_r <= 8'h00;
      end
      // accept a combinable write when the buffer is free or on the same line
      if (comb_wr_w && (!merge_valid_r || (same_line_w && merge_be_r != 8'hFF) ||
          (drain_w && !bus_wr_valid_out))) begin
        merge_valid_r <= 1'b1;
        merge_line_r <= acc_addr_in[ADDR_W-1:3];
        for (i = 0; i < `MTRC_MERGE_BYTES; i = i + 1) begin
          if (acc_be_in[i]) begin
            merge_data_r[i*8 +: 8] <= acc_wdata_in[i*8 +: 8];
          end
        end
        if (merge_valid_r && same_line_w && !(drain_w && !bus_wr_valid_out)) begin
          merge_be_r <= merge_be_r | acc_be_in;
        end else begin
          merge_be_r <= acc_be_in;
        end
      end
    end
  end
endmodule

// [pkg/mtrc_consts.vh]
`ifndef MTRC_CONSTS_VH
`define MTRC_CONSTS_VH
// model-specific register address of the range control register
`define MTRC_MSR_ADDR 32'hC0000085
// reset value of the control register
`define MTRC_RESET_VAL 64'h0000000000000000
// field positions inside one 32-bit range half
`define MTRC_UC_BIT 0
`define MTRC_WC_BIT 1
`define MTRC_BASE_LSB 17
`define MTRC_BASE_MSB 31
`define MTRC_MASK_LSB 2
`define MTRC_MASK_MSB 16
// half offsets inside the 64-bit register
`define MTRC_HALF0_LSB 0
`define MTRC_HALF1_LSB 32
// memory type codes
`define MTRC_TYPE_NONE 2'h0
`define MTRC_TYPE_WC 2'h1
`define MTRC_TYPE_UC 2'h2
// merge buffer width in bytes
`define MTRC_MERGE_BYTES 8
`endif

// [core/mtrc_range_match.v]
`timescale 1ns/10ps
`include "mtrc_consts.vh"
// one range: match and type decode, purely combinational
module mtrc_range_match #(
  parameter FIELD_W = 15
) (
  // range descriptor half
  input wire [31:0] desc_in,
  // physical address upper bits
  input wire [FIELD_W-1:0] addr_hi_in,
  // result
  output wire hit_out,
  output wire [1:0] type_out
);
  wire [FIELD_W-1:0] mask_w; // size mask field
  wire [FIELD_W-1:0] base_w; // base field, low 17 address bits implied zero
  wire uc_w; // range uncached flag
  wire wc_w; // range combine flag

  assign mask_w = desc_in[`MTRC_MASK_MSB:`MTRC_MASK_LSB];
  assign base_w = desc_in[`MTRC_BASE_MSB:`MTRC_BASE_LSB]; // [RL7]
  assign uc_w = desc_in[`MTRC_UC_BIT];
  assign wc_w = desc_in[`MTRC_WC_BIT];
  // masked compare; all-zero mask covers the whole space [RL8] [RL15]
  assign hit_out = ((mask_w & base_w) == (mask_w & addr_hi_in));
  // uncached wins over combine, both clear means no effect [RL9]
  assign type_out = uc_w ? `MTRC_TYPE_UC : (wc_w ? `MTRC_TYPE_WC : `MTRC_TYPE_NONE);
endmodule

// [bench/mtrc_props.sv]
`timescale 1ns/10ps
// watches the checker ports: register access, classification, merged bus write
module mtrc_props (
  // clock and reset
  input wire core_clk_in, input wire rst_n_in, input wire clk_en_in,
  // register access
  input wire msr_wr_in, input wire msr_rd_in, input wire [31:0] msr_addr_in,
  input wire [63:0] msr_wdata_in, input wire msr_ack_out, input wire msr_err_out,
  input wire [63:0] range_type_control_out,
  // classification
  input wire acc_valid_in, input wire cls_valid_out, input wire [1:0] cls_type_out,
  input wire cls_no_alloc_out, input wire cls_hit0_out, input wire cls_hit1_out,
  // merged bus write
  input wire bus_ready_in, input wire bus_wr_valid_out, input wire [63:0] bus_wr_data_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // a taken write to the one mapped address
  sequence s_map_wr;
    clk_en_in && msr_wr_in && msr_addr_in == 32'hC0000085;
  endsequence
  property p_wr; s_map_wr |=> msr_ack_out && range_type_control_out == $past(msr_wdata_in); endproperty
  a_wr: assert property (p_wr) else $error("mapped write not stored");
  property p_err;
    clk_en_in && (msr_wr_in || msr_rd_in) && msr_addr_in != 32'hC0000085
      |=> msr_err_out && !msr_ack_out && $stable(range_type_control_out);
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_cls; clk_en_in && acc_valid_in |=> cls_valid_out; endproperty
  a_cls: assert property (p_cls) else $error("no classification");
  property p_alloc; cls_valid_out |-> cls_no_alloc_out == (cls_type_out != 2'h0); endproperty
  a_alloc: assert property (p_alloc) else $error("allocation flag wrong");
  property p_uc0; cls_valid_out && cls_hit0_out && $past(range_type_control_out[0]) |-> cls_type_out == 2'h2; endproperty
  a_uc0: assert property (p_uc0) else $error("range zero uncached lost");
  property p_uc1; cls_valid_out && cls_hit1_out && $past(range_type_control_out[32]) |-> cls_type_out == 2'h2; endproperty
  a_uc1: assert property (p_uc1) else $error("range one uncached lost");
  property p_wc;
    cls_valid_out && cls_hit0_out && !cls_hit1_out && $past(range_type_control_out[1:0]) == 2'h2 |-> cls_type_out == 2'h1;
  endproperty
  a_wc: assert property (p_wc) else $error("combining type wrong");
  property p_none; cls_valid_out && !cls_hit0_out && !cls_hit1_out |-> cls_type_out == 2'h0; endproperty
  a_none: assert property (p_none) else $error("type without hit");
  property p_rst; disable iff (1'b0) !rst_n_in |=> range_type_control_out == 64'h0 && !cls_valid_out; endproperty
  a_rst: assert property (p_rst) else $error("reset did not clear");
  property p_hold; bus_wr_valid_out && !bus_ready_in |=> bus_wr_valid_out && $stable(bus_wr_data_out); endproperty
  a_hold: assert property (p_hold) else $error("bus write dropped");
endmodule
bind mtrc_checker mtrc_props u_props (.*);

// [bench/mtrc_bus_model.sv]
`timescale 1ns/10ps
// far-side bus: accepts a merged write after STALL held cycles
module mtrc_bus_model #(parameter STALL = 3) (
  // clock and write request
  input wire core_clk_in,
  input wire bus_wr_valid_in,
  // acceptance pulse
  output reg bus_ready_out
);
  reg [3:0] wait_r; // held-cycle count
  initial begin
    bus_ready_out = 1'b0;
    wait_r = 4'h0;
  end
  // one-cycle ready once the stall has run out
  always @(posedge core_clk_in) begin
    bus_ready_out <= bus_wr_valid_in && !bus_ready_out && wait_r == STALL;
    wait_r <= (bus_wr_valid_in && !bus_ready_out && wait_r != STALL) ? wait_r + 4'h1 : 4'h0;
  end
endmodule

// [bench/testbench.sv]
`timescale 1ns/10ps
module testbench;
  reg core_clk_in = 1'b0, rst_n_in = 1'b0, clk_en_in = 1'b1, flush_in = 1'b0;
  reg msr_wr_in = 1'b0, msr_rd_in = 1'b0, acc_valid_in = 1'b0, acc_write_in = 1'b0;
  reg [31:0] msr_addr_in = 32'h0, acc_addr_in = 32'h0;
  reg [63:0] msr_wdata_in = 64'h0, acc_wdata_in = 64'h0;
  reg [7:0] acc_be_in = 8'h0;
  wire [63:0] msr_rdata_out, bus_wr_data_out, range_type_control_out;
  wire [31:0] bus_wr_addr_out;
  wire [7:0] bus_wr_be_out;
  wire [1:0] cls_type_out;
  wire msr_ack_out, msr_err_out, cls_valid_out, cls_no_alloc_out, cls_hit0_out, cls_hit1_out;
  wire bus_ready_in, bus_wr_valid_out;
  integer mismatches = 0, tests_run = 0, n;
  localparam [31:0] REG_A = 32'hC0000085;
  always #2 core_clk_in = ~core_clk_in;
  mtrc_checker i_dut (.*);
  mtrc_bus_model i_bus (.core_clk_in(core_clk_in), .bus_wr_valid_in(bus_wr_valid_out), .bus_ready_out(bus_ready_in));
  task check(input [103:0] seen, input [103:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one register access, answer checked the cycle after
  task model_specific_register(input wr, input [31:0] a, input [63:0] d, input [65:0] exp);
    begin
      msr_wr_in = wr; msr_rd_in = !wr; msr_addr_in = a; msr_wdata_in = d;
      @(negedge core_clk_in); msr_wr_in = 1'b0; msr_rd_in = 1'b0;
      check({msr_ack_out, msr_err_out, msr_rdata_out}, exp);
      @(negedge core_clk_in);
    end
  endtask
  // one access, classification checked the cycle after
  task acc(input w, input [31:0] a, input [7:0] be, input [63:0] d, input [5:0] exp);
    begin
      acc_valid_in = 1'b1; acc_write_in = w; acc_addr_in = a; acc_be_in = be; acc_wdata_in = d;
      @(negedge core_clk_in); acc_valid_in = 1'b0;
      check({cls_valid_out, cls_type_out, cls_no_alloc_out, cls_hit0_out, cls_hit1_out}, exp);
      @(negedge core_clk_in);
    end
  endtask
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    check(range_type_control_out, 104'h0);
    model_specific_register(0, REG_A, 0, {2'b10, 64'h0});
    // range zero 16M at 16M uncached, range one 8M at 1G combining; aligned, contiguous masks
    model_specific_register(1, REG_A, 64'h4001FF02_0101FE01, {2'b10, 64'h0});
    model_specific_register(0, REG_A, 0, {2'b10, 64'h4001FF02_0101FE01});
    model_specific_register(1, 32'hC0000084, 64'hFFFF, {2'b01, 64'h0});
    check(range_type_control_out, 104'h4001FF02_0101FE01);
    $display("test registers done");
    acc(0, 32'h01800000, 0, 0, 6'h36);
    acc(0, 32'h02000000, 0, 0, 6'h20);
    acc(0, 32'h407FFFFC, 0, 0, 6'h2D);
    acc(0, 32'h40800000, 0, 0, 6'h20);
    // range zero covers everything as combining, range one turns uncached
    model_specific_register(1, REG_A, 64'h4001FF01_00000002, {2'b10, 64'h0});
    acc(0, 32'h40000000, 0, 0, 6'h37);
    acc(0, 32'h10000000, 0, 0, 6'h2E);
    $display("test classify done");
    acc(1, 32'h00000100, 8'h0F, 64'h11223344, 6'h2E);
    acc(1, 32'h00000100, 8'hF0, 64'h55667788_00000000, 6'h2E);
    n = 0;
    while (bus_wr_valid_out !== 1'b1 && n < 20) begin
      @(negedge core_clk_in);
      n = n + 1;
    end
    check({bus_wr_be_out, bus_wr_addr_out, bus_wr_data_out}, {8'hFF, 32'h100, 64'h5566778811223344});
    repeat (8) @(negedge core_clk_in);
    // a lone partial write leaves only on flush, with its own byte lanes
    acc(1, 32'h00000200, 8'h03, 64'h0000AABB, 6'h2E);
    flush_in = 1'b1;
    @(negedge core_clk_in);
    flush_in = 1'b0;
    n = 0;
    while (bus_wr_valid_out !== 1'b1 && n < 20) begin
      @(negedge core_clk_in);
      n = n + 1;
    end
    check({bus_wr_be_out, bus_wr_addr_out, bus_wr_data_out[15:0]}, {8'h03, 32'h200, 16'hAABB});
    repeat (8) @(negedge core_clk_in);
    $display("test merge done");
    // enable low: a mapped write must not land
    clk_en_in = 1'b0;
    model_specific_register(1, REG_A, 64'h0, {2'b00, 64'h0});
    check(range_type_control_out, 104'h4001FF01_00000002);
    clk_en_in = 1'b1;
    $display("test enable done");
    summarize;
  end
  // hang guard
  initial begin
    #4000;
    mismatches = mismatches + 1;
    summarize;
  end
endmodule
